/* File: shared/touch_map.vh */
`ifndef TOUCH_MAP_VH
`define TOUCH_MAP_VH
// Notes on behaviour
// - panel interrupt, active low, on own input
// - drive bus clock out, data open-drain
// - decode read data into points, count, gesture
// - valid strobe only when all outputs hold data
// - five points, X coordinate ten bits
// - Y coordinate nine bits beside X
// - touch count two bits, values 0 to 2
// - swipes: up 10, left 14, down 18, right 1C
// - zoom in 48, zoom out 49, none 00

// bus timing: clock rate and bus clock rate in kHz
`define TP_CLK_KHZ      40000
`define TP_SCL_KHZ      100
// quarter bus period in clk cycles: clock over four bus clocks, rounded up
// so the bus never runs fast; sized to meet the 16-bit phase counter
`define TP_QTR_CYC      16'h0064

// target address (arbitrary value) and first data register
`define TP_DEV_ADDR     7'h2A
`define TP_START_REG    8'h00

// read layout: gesture, count, then X hi, X lo, Y hi, Y lo per point
`define TP_READ_LEN     22
`define TP_OFS_GESTURE  0
`define TP_OFS_COUNT    1
`define TP_OFS_POINT    2
`define TP_POINT_BYTES  4

// byte engine commands
`define TP_CMD_START    2'h0
`define TP_CMD_WRITE    2'h1
`define TP_CMD_READ     2'h2
`define TP_CMD_STOP     2'h3

// gesture codes
`define TP_GEST_UP      8'h10
`define TP_GEST_LEFT    8'h14
`define TP_GEST_DOWN    8'h18
`define TP_GEST_RIGHT   8'h1C
`define TP_GEST_ZIN     8'h48
`define TP_GEST_ZOUT    8'h49
`define TP_GEST_NONE    8'h00

// reset levels
`define TP_RST_COUNT    2'h0
`endif

/* File: verilog/i2c_byte_engine.v */
`include "touch_map.vh"

// one bus condition or byte per command; four quarter phases per bit
module i2c_byte_engine #(
    parameter [15:0] QTR = `TP_QTR_CYC
) (
    input  wire       clk,
    input  wire       reset,
    input  wire       go,
    input  wire [1:0] cmd,
    input  wire [7:0] tx_byte,
    input  wire       send_nack,
    input  wire       sda_in,
    output wire       busy,
    output reg        done,
    output reg  [7:0] rx_byte,
    output reg        nack_seen,
    output reg        scl,
    output reg        sda_oe
);
    localparam [1:0] E_IDLE = 2'h0, E_COND = 2'h1, E_BITS = 2'h2, E_STOP = 2'h3;

    reg [1:0]  st_r;
    reg [1:0]  cmd_r;
    reg [15:0] cnt_r;
    reg [1:0]  ph_r;
    reg [3:0]  bit_r;
    reg [7:0]  sh_r;
    reg        nack_tx_r;
    reg        scl_nxt;
    reg        sda_low_nxt;
    wire       tick = (cnt_r == QTR - 16'h0001);
    wire       wr   = (cmd_r == `TP_CMD_WRITE);

    assign busy = (st_r != E_IDLE);

    // pin levels per phase; start is clocked through a low phase so it
    // also serves as a repeated start after a byte
    always @* begin
        scl_nxt     = scl;
        sda_low_nxt = sda_oe;
        case (st_r)
            E_COND: begin
                scl_nxt     = (ph_r == 2'h1) || (ph_r == 2'h2);
                sda_low_nxt = ph_r[1];
            end
            E_BITS: begin
                scl_nxt     = (ph_r == 2'h1) || (ph_r == 2'h2);
                sda_low_nxt = (bit_r < 4'h8) ? (wr & ~sh_r[7]) : (~wr & ~nack_tx_r);
            end
            E_STOP: begin
                scl_nxt     = (ph_r != 2'h0);
                sda_low_nxt = (ph_r < 2'h2);
            end
            default: begin
                scl_nxt     = scl;
                sda_low_nxt = sda_oe;
            end
        endcase
    end

    // sequencing and data shifting
    always @(posedge clk) begin
        if (reset) begin
            st_r      <= E_IDLE;
            cmd_r     <= `TP_CMD_START;
            cnt_r     <= 16'h0000;
            ph_r      <= 2'h0;
            bit_r     <= 4'h0;
            sh_r      <= 8'h00;
            nack_tx_r <= 1'b0;
            done      <= 1'b0;
            rx_byte   <= 8'h00;
            nack_seen <= 1'b0;
            scl       <= 1'b1;
            sda_oe    <= 1'b0;
        end else begin
            done   <= 1'b0;
            scl    <= scl_nxt;
            sda_oe <= sda_low_nxt;
            if (st_r == E_IDLE) begin
                cnt_r <= 16'h0000;
                ph_r  <= 2'h0;
                bit_r <= 4'h0;
                if (go) begin
                    cmd_r     <= cmd;
                    sh_r      <= tx_byte;
                    nack_tx_r <= send_nack;
                    case (cmd)
                        `TP_CMD_START: st_r <= E_COND;
                        `TP_CMD_STOP:  st_r <= E_STOP;
                        default:       st_r <= E_BITS;
                    endcase
                end
            end else if (!tick) begin
                cnt_r <= cnt_r + 16'h0001;
            end else begin
                cnt_r <= 16'h0000;
                ph_r  <= ph_r + 2'h1;
                // sample while the clock is high
                if (st_r == E_BITS && ph_r == 2'h2) begin
                    if (bit_r == 4'h8)
                        nack_seen <= sda_in;
                    else if (!wr)
                        sh_r <= {sh_r[6:0], sda_in};
                end
                if (ph_r == 2'h3) begin
                    if (st_r == E_BITS && wr && bit_r < 4'h8)
                        sh_r <= {sh_r[6:0], 1'b0};
                    if (st_r != E_BITS || bit_r == 4'h8) begin
                        st_r <= E_IDLE;
                        done <= 1'b1;
                        if (st_r == E_BITS && !wr)
                            rx_byte <= sh_r;
                    end
                    bit_r <= bit_r + 4'h1;
                end
            end
        end
    end
endmodule // i2c_byte_engine

/* File: verilog/touch_panel_gesture_reader.v */
`include "touch_map.vh"

// reads the touch controller on interrupt and presents the decoded frame
module touch_panel_gesture_reader #(
    parameter [6:0] DEV_ADDR  = `TP_DEV_ADDR,
    parameter [7:0] START_REG = `TP_START_REG,
    parameter       READ_LEN  = `TP_READ_LEN,
    parameter       X_W       = 10,
    parameter       Y_W       = 9,
    parameter       COUNT_W   = 2,
    parameter [1:0] COUNT_MAX = 2'h2,
    parameter [15:0] QTR      = `TP_QTR_CYC
) (
    input  wire               clk,
    input  wire               reset,
    input  wire               panel_irq_n,
    output wire               panel_bus_clock,
    input  wire               panel_bus_data_in,
    output wire               panel_bus_data_out,
    output wire               panel_bus_data_oe,
    output reg                touch_valid,
    output reg  [X_W-1:0]     point1_x,
    output reg  [Y_W-1:0]     point1_y,
    output reg  [X_W-1:0]     point2_x,
    output reg  [Y_W-1:0]     point2_y,
    output reg  [X_W-1:0]     point3_x,
    output reg  [Y_W-1:0]     point3_y,
    output reg  [X_W-1:0]     point4_x,
    output reg  [Y_W-1:0]     point4_y,
    output reg  [X_W-1:0]     point5_x,
    output reg  [Y_W-1:0]     point5_y,
    output reg  [COUNT_W-1:0] touch_count,
    output reg  [7:0]         gesture_code
);
    localparam [3:0] ST_IDLE   = 4'h0,
                     ST_START  = 4'h1,
                     ST_ADDRW  = 4'h2,
                     ST_REG    = 4'h3,
                     ST_RSTART = 4'h4,
                     ST_ADDRR  = 4'h5,
                     ST_READ   = 4'h6,
                     ST_STOP   = 4'h7,
                     ST_DECODE = 4'h8,
                     ST_REARM  = 4'h9;
    localparam [4:0] LAST_IDX = READ_LEN[4:0] - 5'h01;

    reg [3:0] state_r;
    reg       pend_r;
    reg       err_r;
    reg [4:0] idx_r;
    reg [7:0] frame_r [0:READ_LEN-1];
    reg [1:0] cmd;
    reg [7:0] tx_byte;
    reg       cmd_state;
    wire      eng_done;
    wire      eng_nack;
    wire [7:0] rx_byte;
    wire      eng_go = cmd_state & ~pend_r;

    // X from the low bits of the high byte and the low byte
    function [X_W-1:0] pick_x;
        input [7:0] hi;
        input [7:0] lo;
        reg   [15:0] w;
        begin
            w      = {hi, lo};
            pick_x = w[X_W-1:0];
        end
    endfunction

    function [Y_W-1:0] pick_y;
        input [7:0] hi;
        input [7:0] lo;
        reg   [15:0] w;
        begin
            w      = {hi, lo};
            pick_y = w[Y_W-1:0];
        end
    endfunction

    // codes outside the known set read as no gesture so the host
    // only ever compares against the defined values
    function [7:0] map_gesture;
        input [7:0] raw;
        begin
            case (raw)
                `TP_GEST_UP, `TP_GEST_LEFT,
                `TP_GEST_DOWN, `TP_GEST_RIGHT: map_gesture = raw;
                `TP_GEST_ZIN, `TP_GEST_ZOUT:   map_gesture = raw;
                default:                       map_gesture = `TP_GEST_NONE;
            endcase
        end
    endfunction

    // a count above the supported range is clamped, not wrapped
    function [COUNT_W-1:0] clamp_count;
        input [7:0] raw;
        begin
            if (raw > {6'h00, COUNT_MAX})
                clamp_count = COUNT_MAX[COUNT_W-1:0];
            else
                clamp_count = raw[COUNT_W-1:0];
        end
    endfunction

    // open-drain data: only ever pulled low
    assign panel_bus_data_out = 1'b0;

    i2c_byte_engine #(
        .QTR (QTR)
    ) u_engine (
        .clk       (clk),
        .reset     (reset),
        .go        (eng_go),
        .cmd       (cmd),
        .tx_byte   (tx_byte),
        .send_nack (idx_r == LAST_IDX),
        .sda_in    (panel_bus_data_in),
        .busy      (),
        .done      (eng_done),
        .rx_byte   (rx_byte),
        .nack_seen (eng_nack),
        .scl       (panel_bus_clock),
        .sda_oe    (panel_bus_data_oe)
    );

    // command for each transaction step
    always @* begin
        cmd       = `TP_CMD_START;
        tx_byte   = 8'h00;
        cmd_state = 1'b1;
        case (state_r)
            ST_START, ST_RSTART: cmd = `TP_CMD_START;
            ST_ADDRW: begin
                cmd     = `TP_CMD_WRITE;
                tx_byte = {DEV_ADDR, 1'b0};
            end
            ST_REG: begin
                cmd     = `TP_CMD_WRITE;
                tx_byte = START_REG;
            end
            ST_ADDRR: begin
                cmd     = `TP_CMD_WRITE;
                tx_byte = {DEV_ADDR, 1'b1};
            end
            ST_READ: cmd = `TP_CMD_READ;
            ST_STOP: cmd = `TP_CMD_STOP;
            default: cmd_state = 1'b0;
        endcase
    end

    // received bytes land in the frame store in order
    always @(posedge clk) begin
        if (state_r == ST_READ && eng_done)
            frame_r[idx_r] <= rx_byte;
    end

    // transaction sequencer
    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            pend_r  <= 1'b0;
            err_r   <= 1'b0;
            idx_r   <= 5'h00;
        end else begin
            if (eng_go)
                pend_r <= 1'b1;
            else if (eng_done)
                pend_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    idx_r <= 5'h00;
                    err_r <= 1'b0;
                    if (!panel_irq_n)
                        state_r <= ST_START;
                end
                ST_START:  if (eng_done) state_r <= ST_ADDRW;
                ST_ADDRW:  if (eng_done) begin
                    err_r   <= eng_nack;
                    state_r <= eng_nack ? ST_STOP : ST_REG;
                end
                ST_REG:    if (eng_done) begin
                    err_r   <= eng_nack;
                    state_r <= eng_nack ? ST_STOP : ST_RSTART;
                end
                ST_RSTART: if (eng_done) state_r <= ST_ADDRR;
                ST_ADDRR:  if (eng_done) begin
                    err_r   <= eng_nack;
                    state_r <= eng_nack ? ST_STOP : ST_READ;
                end
                ST_READ:   if (eng_done) begin
                    if (idx_r == LAST_IDX)
                        state_r <= ST_STOP;
                    else
                        idx_r <= idx_r + 5'h01;
                end
                // a refused address abandons the frame without a strobe
                ST_STOP:   if (eng_done) state_r <= err_r ? ST_REARM : ST_DECODE;
                ST_DECODE: state_r <= ST_REARM;
                // wait for the interrupt to clear so one event reads once
                ST_REARM:  if (panel_irq_n) state_r <= ST_IDLE;
                default:   state_r <= ST_IDLE;
            endcase
        end
    end

    // outputs load in the same edge the strobe rises, so they are
    // settled for the whole strobe cycle and held until the next frame
    always @(posedge clk) begin
        if (reset) begin
            touch_valid  <= 1'b0;
            point1_x     <= {X_W{1'b0}};
            point1_y     <= {Y_W{1'b0}};
            point2_x     <= {X_W{1'b0}};
            point2_y     <= {Y_W{1'b0}};
            point3_x     <= {X_W{1'b0}};
            point3_y     <= {Y_W{1'b0}};
            point4_x     <= {X_W{1'b0}};
            point4_y     <= {Y_W{1'b0}};
            point5_x     <= {X_W{1'b0}};
            point5_y     <= {Y_W{1'b0}};
            touch_count  <= {COUNT_W{1'b0}};
            gesture_code <= `TP_GEST_NONE;
        end else begin
            touch_valid <= (state_r == ST_DECODE);
            if (state_r == ST_DECODE) begin
                gesture_code <= map_gesture(frame_r[`TP_OFS_GESTURE]);
                touch_count  <= clamp_count(frame_r[`TP_OFS_COUNT]);
                point1_x <= pick_x(frame_r[2], frame_r[3]);
                point1_y <= pick_y(frame_r[4], frame_r[5]);
                point2_x <= pick_x(frame_r[6], frame_r[7]);
                point2_y <= pick_y(frame_r[8], frame_r[9]);
                point3_x <= pick_x(frame_r[10], frame_r[11]);
                point3_y <= pick_y(frame_r[12], frame_r[13]);
                point4_x <= pick_x(frame_r[14], frame_r[15]);
                point4_y <= pick_y(frame_r[16], frame_r[17]);
                point5_x <= pick_x(frame_r[18], frame_r[19]);
                point5_y <= pick_y(frame_r[20], frame_r[21]);
            end
        end
    end
endmodule // touch_panel_gesture_reader

/* File: tb/touch_reader_sva.sv */
module touch_reader_sva #(
    parameter [15:0] QTR = 16'h0064
) (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       panel_irq_n,
    input wire logic       panel_bus_clock,
    input wire logic       panel_bus_data_out,
    input wire logic       panel_bus_data_oe,
    input wire logic       touch_valid,
    input wire logic [9:0] point1_x,
    input wire logic [1:0] touch_count,
    input wire logic [7:0] gesture_code
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int START_MAX = 3 * QTR + 4;
    localparam int STOP_GAP = 2 * QTR + 4;
    logic       scl_r;
    logic       oe_r;
    logic [7:0] gap_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // cycles since the last stop; saturates so a long idle never wraps
    always_ff @(posedge clk) begin
        scl_r <= panel_bus_clock;
        oe_r <= panel_bus_data_oe;
        if (reset) gap_r <= 8'hFF;
        else if (scl_r && panel_bus_clock && oe_r && !panel_bus_data_oe) gap_r <= 8'h00;
        else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
    end
    // interrupt falls on an idle, rearmed bus
    sequence irq_armed;
        panel_irq_n [*8] ##1 !panel_irq_n && panel_bus_clock && !panel_bus_data_oe;
    endsequence
    // clock drops three edges on (sequencer, engine, pin register),
    // then data is pulled while the clock is high
    sequence bus_begins;
        ##3 !panel_bus_clock ##[1:START_MAX] panel_bus_clock && panel_bus_data_oe;
    endsequence
    start_on_irq_a: assert property (irq_armed |-> bus_begins)
        else $error("bus did not start after interrupt");
    valid_pulse_a: assert property (touch_valid |=> !touch_valid)
        else $error("strobe longer than one cycle");
    count_range_a: assert property (touch_count <= 2'h2)
        else $error("touch count above two");
    gesture_legal_a: assert property (
        gesture_code inside {8'h00, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h48, 8'h49})
        else $error("gesture code outside the table");
    outputs_hold_a: assert property (!touch_valid |->
        $stable(gesture_code) && $stable(touch_count) && $stable(point1_x))
        else $error("outputs changed without strobe");
    data_low_a: assert property (panel_bus_data_out == 1'b0)
        else $error("data line driven high");
    valid_idle_a: assert property (touch_valid |-> panel_bus_clock && !panel_bus_data_oe)
        else $error("strobe while bus busy");
    valid_stop_a: assert property (touch_valid |-> gap_r <= STOP_GAP)
        else $error("strobe without a recent stop");
    reset_quiet_a: assert property ($fell(reset) |-> !touch_valid &&
        touch_count == 2'h0 && gesture_code == 8'h00 && panel_bus_clock && !panel_bus_data_oe)
        else $error("outputs not at reset values");
endmodule // touch_reader_sva

bind touch_panel_gesture_reader touch_reader_sva #(.QTR(QTR)) touch_reader_sva_i (
    .clk, .reset, .panel_irq_n, .panel_bus_clock, .panel_bus_data_out,
    .panel_bus_data_oe, .touch_valid, .point1_x, .touch_count, .gesture_code
);

/* File: tb/touch_chip_model.sv */
module touch_chip_model #(
    parameter [6:0] ADDR = 7'h2A // arbitrary bus address
) (
    input wire logic         scl,
    input wire logic         sda,
    input wire logic [175:0] frame,
    input wire logic         refuse,
    output logic             pull
);
    timeunit 1ns;
    timeprecision 1ps;
    int         bitn = 0;
    int         nbyte = 0;
    logic       rd = 1'b0;
    logic       active = 1'b0;
    logic       mnack = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] cur;
    initial pull = 1'b0;
    // start or repeated start: data falls while clock high
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b1;
            // the start's own clock fall brings this to zero
            bitn = -1;
            nbyte = 0;
            rd = 1'b0;
            mnack = 1'b0;
        end
    end
    // stop: data rises while clock high; let go of the line
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            active = 1'b0;
            pull = 1'b0;
        end
    end
    // bits taken while the clock is high, msb first
    always @(posedge scl) begin
        if (active && bitn < 8) sh = {sh[6:0], sda};
        else if (active && rd && nbyte > 0) mnack = sda;
    end
    // answers only change while the clock is low
    always @(negedge scl) begin
        if (active) begin
            bitn = bitn + 1;
            pull = 1'b0;
            if (bitn == 9) begin
                bitn = 0;
                nbyte = nbyte + 1;
            end else if (bitn == 8 && nbyte == 0) begin
                rd = sh[0];
                pull = (sh[7:1] == ADDR) && !refuse;
            end else if (bitn == 8 && !rd) begin
                pull = 1'b1;
            end
            if (rd && nbyte > 0 && bitn < 8 && !mnack) begin
                cur = frame[175 - 8 * (nbyte - 1) -: 8];
                pull = !cur[7 - bitn];
            end
        end
    end
endmodule // touch_chip_model

/* File: tb/test_touch_panel_gesture_reader.sv */
module test_touch_panel_gesture_reader;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic         panel_irq_n = 1'b1;
    logic         refuse = 1'b0;
    logic [175:0] frame = '0;
    logic [31:0]  lfsr = 32'h9F361965;
    logic [7:0]   codes [8] = '{8'h33, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h00, 8'h48, 8'h49};
    int           num_errors = 0;
    int           comparisons = 0;
    wire          panel_bus_clock;
    wire          panel_bus_data_out;
    wire          panel_bus_data_oe;
    wire          pull;
    wire          touch_valid;
    wire [9:0]    px [5];
    wire [8:0]    py [5];
    wire [1:0]    touch_count;
    wire [7:0]    gesture_code;
    // open-drain data line with its pull-up
    wire          sda = !(panel_bus_data_oe || pull);
    always #12.5 clk = ~clk;
    touch_panel_gesture_reader #(.QTR(16'h0004)) touch_panel_gesture_reader_i (
        .clk(clk), .reset(reset), .panel_irq_n(panel_irq_n),
        .panel_bus_clock(panel_bus_clock), .panel_bus_data_in(sda),
        .panel_bus_data_out(panel_bus_data_out), .panel_bus_data_oe(panel_bus_data_oe),
        .touch_valid(touch_valid), .point1_x(px[0]), .point1_y(py[0]),
        .point2_x(px[1]), .point2_y(py[1]), .point3_x(px[2]), .point3_y(py[2]),
        .point4_x(px[3]), .point4_y(py[3]), .point5_x(px[4]), .point5_y(py[4]),
        .touch_count(touch_count), .gesture_code(gesture_code)
    );
    touch_chip_model touch_chip_model_i (
        .scl(panel_bus_clock), .sda(sda), .frame(frame), .refuse(refuse), .pull(pull)
    );
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // unknown codes are reported as no gesture
    function automatic logic [7:0] gest_of(input logic [7:0] raw);
        case (raw)
            8'h10, 8'h14, 8'h18, 8'h1C, 8'h48, 8'h49: return raw;
            default: return 8'h00;
        endcase
    endfunction
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge clk);
        #2;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check_idle();
        check("strobe", 16'h0000, 16'(touch_valid));
        check("count", 16'h0000, 16'(touch_count));
        check("gesture", 16'h0000, 16'(gesture_code));
        check("x1", 16'h0000, 16'(px[0]));
        check("bus", 16'h0002, 16'({panel_bus_clock, panel_bus_data_oe}));
    endtask
    // one interrupt-driven read of random points, then no restart while irq stays low
    task automatic run_frame(input logic [7:0] code);
        int n;
        logic [15:0] w;
        frame[175:168] = code;
        for (int k = 2; k < 22; k++) begin
            lfsr = step(lfsr);
            frame[175 - 8 * k -: 8] = lfsr[7:0];
        end
        // raw counts up to 7 so the clamp sees values whose low bits wrap
        frame[167:160] = {5'h00, lfsr[10:8]};
        panel_irq_n = 1'b0;
        n = 0;
        while (touch_valid !== 1'b1 && n < 6000) begin
            tick();
            n++;
        end
        check("strobe", 16'h0001, 16'(touch_valid));
        check("gesture", 16'(gest_of(code)), 16'(gesture_code));
        w = (lfsr[10:8] > 3'h2) ? 16'h0002 : 16'(lfsr[10:8]);
        check("count", w, 16'(touch_count));
        for (int i = 0; i < 5; i++) begin
            w = frame[159 - 32 * i -: 16];
            check("x", {6'h00, w[9:0]}, 16'(px[i]));
            w = frame[143 - 32 * i -: 16];
            check("y", {7'h00, w[8:0]}, 16'(py[i]));
        end
        n = 0;
        repeat (200) begin
            tick();
            if (panel_bus_clock !== 1'b1 || touch_valid !== 1'b0) n++;
        end
        check("rearm", 16'h0000, 16'(n));
        panel_irq_n = 1'b1;
        repeat (12) tick();
    endtask
    initial begin
        int n;
        repeat (5) @(posedge clk);
        #2;
        reset = 1'b0;
        tick();
        check_idle();
        foreach (codes[i]) run_frame(codes[i]);
        // refused address: no strobe and last frame held
        refuse = 1'b1;
        panel_irq_n = 1'b0;
        n = 0;
        repeat (1500) begin
            tick();
            if (touch_valid === 1'b1) n++;
        end
        check("refused", 16'h0000, 16'(n));
        check("held", 16'h0049, 16'(gesture_code));
        panel_irq_n = 1'b1;
        refuse = 1'b0;
        repeat (12) tick();
        run_frame(8'h14);
        reset = 1'b1;
        repeat (5) tick();
        reset = 1'b0;
        tick();
        check_idle();
        give_verdict();
    end
    // hang guard: about twice the expected run
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule // test_touch_panel_gesture_reader
